/* verilog/rom_io_ports.sv */
// Processor side of a byte memory with two 8-bit general purpose ports.
// All bus strobes are treated as synchronous inputs and their edges are
// detected in the system clock, so each strobe edge acts exactly once.
module rom_io_ports
	import romio_pkg::*;
(
	input  wire logic              MCLK_I,
	input  wire logic              RST_N_I,
	input  wire logic              ADDR_LATCH_I,
	input  wire logic [DATA_W-1:0] MUXED_ADDR_DATA_BUS_I,
	output logic      [DATA_W-1:0] MUXED_ADDR_DATA_BUS_O,
	output logic                   MUXED_ADDR_DATA_BUS_OE_O,
	input  wire logic [2:0]        UPPER_MEM_ADDR_I,
	input  wire logic              IO_SEL_I,
	input  wire logic              CHIP_EN_N_I,
	input  wire logic              CHIP_EN_I,
	input  wire logic              READ_STROBE_N_I,
	input  wire logic              IO_READ_STROBE_N_I,
	input  wire logic              IO_WRITE_STROBE_N_I,
	input  wire logic              BUS_CLK_I,
	input  wire logic              PORT_RESET_I,
	output logic                   WAIT_O,
	output logic                   WAIT_OE_O,
	input  wire logic [DATA_W-1:0] FIRST_PORT_PINS_I,
	output logic      [DATA_W-1:0] FIRST_PORT_PINS_O,
	output logic      [DATA_W-1:0] FIRST_PORT_PINS_OE_O,
	input  wire logic [DATA_W-1:0] SECOND_PORT_PINS_I,
	output logic      [DATA_W-1:0] SECOND_PORT_PINS_O,
	output logic      [DATA_W-1:0] SECOND_PORT_PINS_OE_O
);
	import romio_pkg::*;

	// Previous samples of the strobes for edge detection.
	logic ale_q;
	logic rd_n_q;
	logic ior_n_q;
	logic iow_n_q;
	logic bclk_q;
	latch_t lat_q;
	latch_t lat_d;
	port_t first_q;
	port_t second_q;
	logic [7:0] pend_q;
	logic [1:0] pend_sel_q;
	logic pend_vld_q;
	logic wait_q;
	logic wait_d;
	logic rd_act_q;
	logic rd_mem_q;
	logic [1:0] rd_sel_q;
	logic [7:0] rom_data;
	logic [7:0] bus_data;
	logic [7:0] rd_port_data;

	// Strobe edges; falling edges start actions, the rising edge ends them.
	wire ale_fall  = ale_q & ~ADDR_LATCH_I;
	wire rd_fall   = rd_n_q & ~READ_STROBE_N_I;
	wire ior_fall  = ior_n_q & ~IO_READ_STROBE_N_I;
	wire iow_fall  = iow_n_q & ~IO_WRITE_STROBE_N_I;
	wire iow_rise  = ~iow_n_q & IO_WRITE_STROBE_N_I;
	wire bclk_rise = ~bclk_q & BUS_CLK_I;
	wire en_live   = ~CHIP_EN_N_I & CHIP_EN_I;
	wire both_hi   = READ_STROBE_N_I & IO_READ_STROBE_N_I;

	// Capture at the trailing edge of the latch strobe; held for the cycle.
	always_comb begin
		lat_d = lat_q;
		if (ale_fall) begin
			lat_d.addr   = {UPPER_MEM_ADDR_I, MUXED_ADDR_DATA_BUS_I};
			lat_d.io_sel = IO_SEL_I;
			lat_d.en_ok  = en_live;
		end
	end

	// Only the two low bits take part in port decode; upper ones are unused.
	wire [1:0] io_sel_bits = lat_q.addr[1:0];
	wire       sel_is_dir  = io_sel_bits[1];
	wire       sel_second  = io_sel_bits[0];

	// Port reads: io strobe, or general read with I/O select high.
	wire port_rd = lat_q.en_ok & (ior_fall | (rd_fall & lat_q.io_sel));
	wire mem_rd  = lat_q.en_ok & rd_fall & ~lat_q.io_sel;

	// Pin value read back in both modes, data of a direction read is zero.
	// The selection is the one held since the read strobe fell.
	assign rd_port_data = rd_sel_q[1] ? 8'h00 :
		(rd_sel_q[0] ? SECOND_PORT_PINS_I : FIRST_PORT_PINS_I);
	assign bus_data = rd_mem_q ? rom_data : rd_port_data;

	// Wait is pulled low once enables are live during the strobe high time, until the first bus clock rise after the strobe falls.
	always_comb begin
		wait_d = wait_q;
		if (ADDR_LATCH_I & en_live) begin
			wait_d = 1'b1;
		end else if (bclk_rise) begin
			wait_d = 1'b0;
		end
	end

	rom_store u_rom (
		.clk_i  (MCLK_I),
		.addr_i (lat_q.addr),
		.data_o (rom_data)
	);

	// Strobe history and address latch.
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			ale_q   <= 1'b0;
			rd_n_q  <= 1'b1;
			ior_n_q <= 1'b1;
			iow_n_q <= 1'b1;
			bclk_q  <= 1'b0;
			lat_q   <= '0;
			wait_q  <= 1'b0;
		end else begin
			ale_q   <= ADDR_LATCH_I;
			rd_n_q  <= READ_STROBE_N_I;
			ior_n_q <= IO_READ_STROBE_N_I;
			iow_n_q <= IO_WRITE_STROBE_N_I;
			bclk_q  <= BUS_CLK_I;
			lat_q   <= lat_d;
			wait_q  <= wait_d;
		end
	end

	// Read tracking: the source is chosen at the strobe fall and held.
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			rd_act_q <= 1'b0;
			rd_mem_q <= 1'b0;
			rd_sel_q <= SEL_FIRST_DATA;
		end else if (both_hi | ~lat_q.en_ok) begin
			rd_act_q <= 1'b0;
		end else if (mem_rd | port_rd) begin
			rd_act_q <= 1'b1;
			rd_mem_q <= mem_rd;
			rd_sel_q <= io_sel_bits;
		end
	end

	// Write capture at the strobe fall; the io select is not consulted.
	// The byte is staged so pins only move when the strobe rises again.
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			pend_q     <= 8'h00;
			pend_sel_q <= SEL_FIRST_DATA;
			pend_vld_q <= 1'b0;
		end else if (iow_fall & lat_q.en_ok) begin
			pend_q     <= MUXED_ADDR_DATA_BUS_I;
			pend_sel_q <= io_sel_bits;
			pend_vld_q <= 1'b1;
		end else if (iow_rise) begin
			pend_vld_q <= 1'b0;
		end
	end

	wire commit = pend_vld_q & iow_rise;

	// Port latches; data latches accept writes whatever the direction.
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			first_q  <= '{data: PORT_RESET, dir: DIR_RESET};
			second_q <= '{data: PORT_RESET, dir: DIR_RESET};
		end else begin
			if (PORT_RESET_I) begin
				first_q.dir  <= DIR_RESET;
				second_q.dir <= DIR_RESET;
			end
			if (commit) begin
				case (pend_sel_q)
					SEL_FIRST_DATA: first_q.data <= pend_q;
					SEL_SECOND_DATA: second_q.data <= pend_q;
					SEL_FIRST_DIR: begin
						if (!PORT_RESET_I) begin
							first_q.dir <= pend_q;
						end
					end
					SEL_SECOND_DIR: begin
						if (!PORT_RESET_I) begin
							second_q.dir <= pend_q;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Registered pad outputs; each driver enabled by its direction bit.
	// Reset also clears the enables at once rather than a cycle later.
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			FIRST_PORT_PINS_O     <= PORT_RESET;
			SECOND_PORT_PINS_O    <= PORT_RESET;
			FIRST_PORT_PINS_OE_O  <= DIR_RESET;
			SECOND_PORT_PINS_OE_O <= DIR_RESET;
		end else begin
			FIRST_PORT_PINS_O     <= first_q.data;
			SECOND_PORT_PINS_O    <= second_q.data;
			FIRST_PORT_PINS_OE_O  <= PORT_RESET_I ? DIR_RESET :
				first_q.dir;
			SECOND_PORT_PINS_OE_O <= PORT_RESET_I ? DIR_RESET :
				second_q.dir;
		end
	end

	// Bus and wait pads; a disabled cycle leaves both floating.
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			MUXED_ADDR_DATA_BUS_O    <= 8'h00;
			MUXED_ADDR_DATA_BUS_OE_O <= 1'b0;
			WAIT_O                   <= 1'b0;
			WAIT_OE_O                <= 1'b0;
		end else begin
			MUXED_ADDR_DATA_BUS_O    <= bus_data;
			MUXED_ADDR_DATA_BUS_OE_O <= rd_act_q & ~both_hi &
				lat_q.en_ok;
			WAIT_O                   <= 1'b0;
			WAIT_OE_O                <= wait_d;
		end
	end

endmodule

/* verilog/romio_pkg.sv */
package romio_pkg;

	localparam int ADDR_W  = 11;
	localparam int DATA_W  = 8;
	localparam int DEPTH   = 2048;

	// Register select codes held in the two lowest latched address bits.
	localparam logic [1:0] SEL_FIRST_DATA  = 2'h0;
	localparam logic [1:0] SEL_SECOND_DATA = 2'h1;
	localparam logic [1:0] SEL_FIRST_DIR   = 2'h2;
	localparam logic [1:0] SEL_SECOND_DIR  = 2'h3;

	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET  = 8'h00;

	// Values captured at the falling edge of the address latch strobe.
	typedef struct packed {
		logic [10:0] addr;
		logic        io_sel;
		logic        en_ok;
	} latch_t;

	// One general purpose port: output latch and direction.
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] dir;
	} port_t;

endpackage

/* verilog/rom_store.sv */
// Read-only byte store; the read data come out of a register.
module rom_store
	import romio_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	output logic      [DATA_W-1:0] data_o
);

	logic [DATA_W-1:0] mem [DEPTH];

	// Contents are a neutral pattern: each byte is its low address bits.
	// A product build would replace this table with the real image.
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = i[DATA_W-1:0];
		end
	end

	// Registered read keeps the store mappable onto block memory.
	always_ff @(posedge clk_i) begin
		data_o <= mem[addr_i];
	end

endmodule

/* verification/pin_model.sv */
module pin_model (
	input  wire logic [15:0] out_i,
	input  wire logic [15:0] oe_i,
	input  wire logic [15:0] ext_i,
	output logic      [15:0] pins_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// A pin shows its latch only while the driver is on.
	assign pins_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

/* verification/port_monitor.sv */
module port_monitor (
	input wire logic       MCLK_I,
	input wire logic       RST_N_I,
	input wire logic       ADDR_LATCH_I,
	input wire logic       CHIP_EN_N_I,
	input wire logic       CHIP_EN_I,
	input wire logic       READ_STROBE_N_I,
	input wire logic       IO_READ_STROBE_N_I,
	input wire logic       IO_WRITE_STROBE_N_I,
	input wire logic       BUS_CLK_I,
	input wire logic       PORT_RESET_I,
	input wire logic       MUXED_ADDR_DATA_BUS_OE_O,
	input wire logic       WAIT_O,
	input wire logic       WAIT_OE_O,
	input wire logic [7:0] FIRST_PORT_PINS_O,
	input wire logic [7:0] FIRST_PORT_PINS_OE_O,
	input wire logic [7:0] SECOND_PORT_PINS_OE_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	// Building blocks: idle read strobes and an enabled latch phase.
	sequence rd_idle;
		READ_STROBE_N_I && IO_READ_STROBE_N_I;
	endsequence
	sequence en_latch;
		ADDR_LATCH_I && !CHIP_EN_N_I && CHIP_EN_I;
	endsequence
	bus_release_a: assert property (
		rd_idle [*3] |-> !MUXED_ADDR_DATA_BUS_OE_O)
		else $error("bus held after reads");
	read_cause_a: assert property (
		$rose(MUXED_ADDR_DATA_BUS_OE_O) |-> !$past(READ_STROBE_N_I, 2)
		|| !$past(IO_READ_STROBE_N_I, 2))
		else $error("bus driven without read");
	wait_start_a: assert property (en_latch |=> WAIT_OE_O)
		else $error("wait missing");
	wait_end_a: assert property (
		$rose(BUS_CLK_I) && !ADDR_LATCH_I |-> ##[1:3] !WAIT_OE_O)
		else $error("wait held too long");
	wait_level_a: assert property (WAIT_OE_O |-> !WAIT_O)
		else $error("wait driven high");
	idle_enable_a: assert property (
		$fell(ADDR_LATCH_I) && (CHIP_EN_N_I || !CHIP_EN_I)
		|-> !MUXED_ADDR_DATA_BUS_OE_O [*8])
		else $error("disabled cycle drove bus");
	port_reset_a: assert property (PORT_RESET_I [*3] |->
		(FIRST_PORT_PINS_OE_O | SECOND_PORT_PINS_OE_O) == 8'h00)
		else $error("port reset left drivers on");
	glitch_free_a: assert property (
		$changed(FIRST_PORT_PINS_O) |-> IO_WRITE_STROBE_N_I
		&& $past(IO_WRITE_STROBE_N_I))
		else $error("pins moved during write");
endmodule
bind rom_io_ports port_monitor u_mon (.*);

/* verification/testbench.sv */
`define CHK(n, e, v) begin \
	compares++; \
	if ((v) !== (e)) begin \
		n_mismatch++; \
		$display("wrong value %s exp %h seen %h", n, e, v); \
	end \
end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, bclk = 1'h0, rst_n = 1'h0, ale = 1'h0, io = 1'h0;
	logic        prst = 1'h0, ce_n = 1'h1, ce = 1'h0, rd_n = 1'h1;
	logic        ior_n = 1'h1, iow_n = 1'h1, boe, wo, woe;
	logic [2:0]  upa = 3'h0;
	logic [7:0]  drv = 8'h00, bo, p1o, p1e, p2o, p2e;
	logic [15:0] pins;
	logic [20:0] rows [6];
	int          n_mismatch = 0, compares = 0;
	wire  [7:0]  busw = boe ? bo : drv;
	rom_io_ports u_dut (.MCLK_I(clk), .RST_N_I(rst_n), .ADDR_LATCH_I(ale),
		.MUXED_ADDR_DATA_BUS_I(busw), .MUXED_ADDR_DATA_BUS_O(bo),
		.MUXED_ADDR_DATA_BUS_OE_O(boe), .UPPER_MEM_ADDR_I(upa),
		.IO_SEL_I(io), .CHIP_EN_N_I(ce_n), .CHIP_EN_I(ce),
		.READ_STROBE_N_I(rd_n), .IO_READ_STROBE_N_I(ior_n),
		.IO_WRITE_STROBE_N_I(iow_n), .BUS_CLK_I(bclk),
		.PORT_RESET_I(prst), .WAIT_O(wo), .WAIT_OE_O(woe),
		.FIRST_PORT_PINS_I(pins[7:0]), .FIRST_PORT_PINS_O(p1o),
		.FIRST_PORT_PINS_OE_O(p1e), .SECOND_PORT_PINS_I(pins[15:8]),
		.SECOND_PORT_PINS_O(p2o), .SECOND_PORT_PINS_OE_O(p2e));
	pin_model u_pins (.out_i({p2o, p1o}), .oe_i({p2e, p1e}),
		.ext_i(16'hc35a), .pins_o(pins));
	// System clock; the bus clock toggles off the falling edge.
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) bclk <= ~bclk;
	// Address phase; the bus then shows a changing pattern.
	task automatic cyc(input logic [10:0] a, input logic i, en);
		@(negedge clk);
		{ale, upa, drv, io, ce_n, ce} = {1'h1, a, i, !en, en};
		repeat (2) @(negedge clk);
		ale = 1'h0;
		repeat (2) @(negedge clk);
		drv = ~a[7:0];
	endtask
	task automatic rd(input logic [10:0] a, input logic i, s,
		input logic [7:0] e);
		cyc(a, i, 1'h1);
		{ior_n, rd_n} = {!s, s};
		repeat (6) @(negedge clk);
		`CHK("read data", e, bo)
		{ior_n, rd_n} = 2'h3;
		repeat (3) @(negedge clk);
		`CHK("bus release", 1'h0, boe)
	endtask
	// Select low keeps memory mode: a write must ignore it.
	task automatic wr(input logic [10:0] a, input logic en,
		input logic [7:0] d);
		cyc(a, 1'h0, en);
		@(negedge clk);
		drv = d;
		iow_n = 1'h0;
		repeat (2) @(negedge clk);
		iow_n = 1'h1;
		repeat (5) @(negedge clk);
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#40us;
		n_mismatch++;
		final_report;
	end
	initial begin
		rows = '{{11'h000, 2'h0, 8'h00}, {11'h7ff, 2'h0, 8'hff},
			{11'h2a5, 2'h0, 8'ha5}, {11'h700, 2'h2, 8'h5a},
			{11'h001, 2'h1, 8'hc3}, {11'h002, 2'h1, 8'h00}};
		repeat (3) @(negedge clk);
		rst_n = 1'h1;
		foreach (rows[i]) begin
			rd(rows[i][20:10], rows[i][9], rows[i][8], rows[i][7:0]);
			$display("row %0d done", i);
		end
		wr(11'h700, 1'h1, 8'h96);
		`CHK("preload", 8'h96, p1o)
		`CHK("dir off", 8'h00, p1e)
		wr(11'h702, 1'h1, 8'hf0);
		`CHK("dir on", 8'hf0, p1e)
		rd(11'h000, 1'h1, 1'h0, 8'h9a);
		wr(11'h003, 1'h0, 8'hff);
		`CHK("disabled", 8'h00, p2e)
		`CHK("wait off", 1'h0, woe)
		`CHK("wait level", 1'h0, wo)
		wr(11'h003, 1'h1, 8'h0f);
		`CHK("dir two", 8'h0f, p2e)
		`CHK("latch two", 8'h00, p2o)
		$display("port tests done");
		prst = 1'h1;
		repeat (3) @(negedge clk);
		prst = 1'h0;
		@(negedge clk);
		`CHK("port reset", 8'h00, p1e | p2e)
		rst_n = 1'h0;
		repeat (3) @(negedge clk);
		rst_n = 1'h1;
		`CHK("reset bus", 1'h0, boe)
		`CHK("reset wait", 1'h0, woe)
		$display("reset tests done");
		final_report;
	end
endmodule
